// >>> ops_pkg.sv
// Shared constants and types for the second-page OTP status block.
package ops_pkg;

   localparam int unsigned STAT_WIDTH = 8;

   // Bit positions within the status word and the interrupt registers.
   localparam int unsigned BIT_LOADED = 7;
   localparam int unsigned BIT_WARN = 6;
   localparam int unsigned BIT_ERR = 5;
   localparam int unsigned BIT_FMT = 4;
   localparam int unsigned BIT_VALID = 3;
   localparam int unsigned BIT_LOW_CLEAR = 2;
   localparam int unsigned BIT_HIGH_CLEAR = 1;
   localparam int unsigned BIT_ATTEMPT = 0;

   // Register indices; the byte address is four times the index.
   localparam logic [11:0] STATUS_IDX = 12'h51B;
   localparam logic [11:0] IRQ_STAT_IDX = 12'h51C;
   localparam logic [11:0] IRQ_MASK_IDX = 12'h51D;
   localparam logic [31:0] STATUS_ADDR = {18'h00000, STATUS_IDX, 2'h0};
   localparam logic [31:0] IRQ_STAT_ADDR = {18'h00000, IRQ_STAT_IDX, 2'h0};
   localparam logic [31:0] IRQ_MASK_ADDR = {18'h00000, IRQ_MASK_IDX, 2'h0};

   // Values after reset.
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] IRQ_STAT_RESET = 8'h00;
   localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
   localparam logic [31:0] RDATA_RESET = 32'h00000000;

   // AHB-Lite encodings; the slave decodes NONSEQ and drives OKAY, the testbench also drives IDLE and the word size.
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'b0;

   typedef enum logic [1:0] {
      OPS_BUS_IDLE = 2'h0,
      OPS_BUS_WRITE = 2'h1,
      OPS_BUS_READ = 2'h3
   } ops_bus_state_e;

endpackage

// >>> ops_edge_detect.sv
// Rising-edge detector for a vector of same-clock levels.
`timescale 1ns/1ps
module ops_edge_detect #(
   parameter int unsigned WIDTH = 8
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Levels in, one-cycle pulses out
   input wire logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise
);

   logic [WIDTH-1:0] levelLast;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         levelLast <= '0;
      end else begin
         levelLast <= level;
      end
   end

   assign rise = level & ~levelLast;

endmodule

// >>> ops_irq_ctrl.sv
// Sticky interrupt status, mask and the single level interrupt output.
`timescale 1ns/1ps
module ops_irq_ctrl #(
   parameter int unsigned WIDTH = 8
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Event pulses
   input wire logic [WIDTH-1:0] evt,
   // Software access
   input wire logic clearWr,
   input wire logic maskWr,
   input wire logic [WIDTH-1:0] wrData,
   // State
   output logic [WIDTH-1:0] irqStat,
   output logic [WIDTH-1:0] irqMask,
   output logic irq
);

   // An event in the same cycle as its write-one clear keeps the bit set.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irqStat <= ops_pkg::IRQ_STAT_RESET;
      end else begin
         irqStat <= (irqStat & ~(clearWr ? wrData : '0)) | evt;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irqMask <= ops_pkg::IRQ_MASK_RESET;
      end else if (maskWr) begin
         irqMask <= wrData;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStat & irqMask);
      end
   end

endmodule

// >>> ops_otp_page2_status.sv
// Status flags of the second OTP page with an AHB-Lite register slave.
//
// How it works
// - Bit 7 rises when page two is chosen and loaded, and falls when it is not chosen.
// - Bit 6 reports that a load of page two needed one or more single-error repairs.
// - Bit 5 reports a double-error detection during the load of the chosen page.
// - Bit 4 goes high one cycle after bit 2 or bit 1 is high while bit 0 is low.
// - Bit 3 reads one after programming of page two finished successfully, or when a load restores it from the page image.
// - Bit 2 is low after a supply undervoltage in an attempt, and low with no attempt unless a page load restores it high.
// - Bit 1 is low after a supply overvoltage in an attempt, and low with no attempt unless a page load restores it high.
// - An overvoltage during programming also records an undervoltage.
// - Bit 0 rises with the first programming attempt, or when a load restores it from the page image.
`timescale 1ns/1ps
module ops_otp_page2_status (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Load sequencer
   input wire logic loadStart,
   input wire logic loadSelect,
   input wire logic loadSecHit,
   input wire logic loadDedHit,
   input wire logic loadDone,
   input wire logic [3:0] loadProgImage,
   // Program sequencer
   input wire logic progStart,
   input wire logic progLowEvt,
   input wire logic progHighEvt,
   input wire logic progDone,
   input wire logic progPass,
   // Status out
   output logic [7:0] statusFlags,
   output logic progPermit,
   output logic retireDevice,
   output logic irq
);

   localparam int unsigned W = ops_pkg::STAT_WIDTH;

   // Returns one when the address selects the given register word.
   function automatic logic hitWord(input logic [31:0] addr, input logic [31:0] base);
      hitWord = (addr[31:2] == base[31:2]);
   endfunction

   // Flag state.
   logic loadActive;
   logic pageLoaded;
   logic correctableWarnFlag;
   logic uncorrectableErrFlag;
   logic formatFaultFlag;
   logic pageValidFlag;
   logic progSupplyLowClear;
   logic progSupplyHighClear;
   logic firstAttemptFlag;
   logic progActive;

   logic [W-1:0] statusWord;
   logic [W-1:0] statusRise;
   logic [W-1:0] irqEvt;
   logic [W-1:0] irqStat;
   logic [W-1:0] irqMask;

   // Bus state.
   ops_pkg::ops_bus_state_e busState;
   ops_pkg::ops_bus_state_e next_busState;
   logic [31:0] dataAddr;
   logic addrTaken;
   logic [31:0] next_rdata;
   logic clearWr;
   logic maskWr;

   // ---- Load side ----

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         loadActive <= 1'b0;
      end else if (loadStart) begin
         loadActive <= loadSelect;
      end else if (loadDone) begin
         loadActive <= 1'b0;
      end
   end

   // A load that does not choose page two clears the loaded indication.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pageLoaded <= 1'b0;
      end else if (loadStart) begin
         pageLoaded <= 1'b0;
      end else if (loadDone && loadActive) begin
         pageLoaded <= 1'b1;
      end
   end

   // Warning and error restart with every load attempt so stale results never linger.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         correctableWarnFlag <= 1'b0;
      end else if (loadStart) begin
         correctableWarnFlag <= 1'b0;
      end else if (loadActive && loadSecHit) begin
         correctableWarnFlag <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         uncorrectableErrFlag <= 1'b0;
      end else if (loadStart) begin
         uncorrectableErrFlag <= 1'b0;
      end else if (loadActive && loadDedHit) begin
         uncorrectableErrFlag <= 1'b1;
      end
   end

   // ---- Program side ----

   // A start is refused while the format fault stands.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         progActive <= 1'b0;
      end else if (progStart && !formatFaultFlag) begin
         progActive <= 1'b1;
      end else if (progDone) begin
         progActive <= 1'b0;
      end
   end

   // The attempt flag is restored from the page image on load, so a damaged
   // image can show supply flags without an attempt; that is the format fault.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         firstAttemptFlag <= 1'b0;
      end else if (progStart && !formatFaultFlag) begin
         firstAttemptFlag <= 1'b1;
      end else if (loadDone && loadActive) begin
         firstAttemptFlag <= loadProgImage[ops_pkg::BIT_ATTEMPT];
      end
   end

   // Both supply flags start high at an attempt; the low flag drops on either fault, the high flag on overvoltage only.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         progSupplyLowClear <= 1'b0;
      end else if (progActive && (progLowEvt || progHighEvt)) begin
         progSupplyLowClear <= 1'b0;
      end else if (progStart && !formatFaultFlag) begin
         progSupplyLowClear <= 1'b1;
      end else if (loadDone && loadActive) begin
         progSupplyLowClear <= loadProgImage[ops_pkg::BIT_LOW_CLEAR];
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         progSupplyHighClear <= 1'b0;
      end else if (progActive && progHighEvt) begin
         progSupplyHighClear <= 1'b0;
      end else if (progStart && !formatFaultFlag) begin
         progSupplyHighClear <= 1'b1;
      end else if (loadDone && loadActive) begin
         progSupplyHighClear <= loadProgImage[ops_pkg::BIT_HIGH_CLEAR];
      end
   end

   // Valid on a passing finish with no supply fault seen, or as restored from the page image on load.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pageValidFlag <= 1'b0;
      end else if (progStart && !formatFaultFlag) begin
         pageValidFlag <= 1'b0;
      end else if (progActive && progDone) begin
         pageValidFlag <= progPass && progSupplyLowClear && progSupplyHighClear
            && !progLowEvt && !progHighEvt;
      end else if (loadDone && loadActive) begin
         pageValidFlag <= loadProgImage[ops_pkg::BIT_VALID];
      end
   end

   // Registered one cycle behind the flags it is derived from.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         formatFaultFlag <= 1'b0;
      end else begin
         formatFaultFlag <= (progSupplyLowClear || progSupplyHighClear)
            && !firstAttemptFlag;
      end
   end

   always_comb begin
      statusWord = ops_pkg::STATUS_RESET;
      statusWord[ops_pkg::BIT_LOADED] = pageLoaded;
      statusWord[ops_pkg::BIT_WARN] = correctableWarnFlag;
      statusWord[ops_pkg::BIT_ERR] = uncorrectableErrFlag;
      statusWord[ops_pkg::BIT_FMT] = formatFaultFlag;
      statusWord[ops_pkg::BIT_VALID] = pageValidFlag;
      statusWord[ops_pkg::BIT_LOW_CLEAR] = progSupplyLowClear;
      statusWord[ops_pkg::BIT_HIGH_CLEAR] = progSupplyHighClear;
      statusWord[ops_pkg::BIT_ATTEMPT] = firstAttemptFlag;
   end

   // ---- Status outputs ----

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         statusFlags <= ops_pkg::STATUS_RESET;
      end else begin
         statusFlags <= statusWord;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         progPermit <= 1'b1;
      end else begin
         progPermit <= !formatFaultFlag;
      end
   end

   // Stays high once an overvoltage has been seen in an attempt.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         retireDevice <= 1'b0;
      end else if (progActive && progHighEvt) begin
         retireDevice <= 1'b1;
      end
   end

   // ---- Interrupt events ----

   ops_edge_detect #(
      .WIDTH(W)
   ) u_edge (
      .ref_clk(ref_clk),
      .rst(rst),
      .level(statusWord),
      .rise(statusRise)
   );

   // Supply faults are signalled by the falling clear bits, so use the raw events.
   always_comb begin
      irqEvt = statusRise;
      irqEvt[ops_pkg::BIT_LOW_CLEAR] = progActive && (progLowEvt || progHighEvt);
      irqEvt[ops_pkg::BIT_HIGH_CLEAR] = progActive && progHighEvt;
   end

   ops_irq_ctrl #(
      .WIDTH(W)
   ) u_irq (
      .ref_clk(ref_clk),
      .rst(rst),
      .evt(irqEvt),
      .clearWr(clearWr),
      .maskWr(maskWr),
      .wrData(hwdata[W-1:0]),
      .irqStat(irqStat),
      .irqMask(irqMask),
      .irq(irq)
   );

   // ---- AHB-Lite slave ----

   // Zero wait states: a taken address phase is answered in the next cycle.
   assign addrTaken = hsel && hready && (htrans == ops_pkg::HTRANS_NONSEQ);

   always_comb begin
      next_busState = ops_pkg::OPS_BUS_IDLE;
      if (addrTaken) begin
         next_busState = hwrite ? ops_pkg::OPS_BUS_WRITE : ops_pkg::OPS_BUS_READ;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         busState <= ops_pkg::OPS_BUS_IDLE;
      end else begin
         busState <= next_busState;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dataAddr <= 32'h00000000;
      end else if (addrTaken) begin
         dataAddr <= haddr;
      end
   end

   // Write data arrives in the data phase; the status word has no write path.
   always_comb begin
      clearWr = 1'b0;
      maskWr = 1'b0;
      case (busState)
         ops_pkg::OPS_BUS_WRITE: begin
            clearWr = hitWord(dataAddr, ops_pkg::IRQ_STAT_ADDR);
            maskWr = hitWord(dataAddr, ops_pkg::IRQ_MASK_ADDR);
         end
         default: begin
            clearWr = 1'b0;
            maskWr = 1'b0;
         end
      endcase
   end

   // Read data is sampled at the address phase so hrdata comes from a flop.
   always_comb begin
      next_rdata = ops_pkg::RDATA_RESET;
      if (addrTaken && !hwrite) begin
         if (hitWord(haddr, ops_pkg::STATUS_ADDR)) begin
            next_rdata[W-1:0] = statusWord;
         end else if (hitWord(haddr, ops_pkg::IRQ_STAT_ADDR)) begin
            next_rdata[W-1:0] = irqStat;
         end else if (hitWord(haddr, ops_pkg::IRQ_MASK_ADDR)) begin
            next_rdata[W-1:0] = irqMask;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hrdata <= ops_pkg::RDATA_RESET;
      end else begin
         hrdata <= next_rdata;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hreadyout <= 1'b1;
         hresp <= ops_pkg::HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp <= ops_pkg::HRESP_OKAY;
      end
   end

endmodule

// >>> ops_otp_page2_status_chk.sv
// Port-level assertions for the second-page OTP status block.
`timescale 1ns/1ps
module ops_otp_page2_status_chk (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Sequencers
   input wire logic loadStart,
   input wire logic loadSelect,
   input wire logic loadSecHit,
   input wire logic loadDedHit,
   input wire logic loadDone,
   input wire logic progStart,
   input wire logic progLowEvt,
   input wire logic progHighEvt,
   input wire logic progDone,
   // Status
   input wire logic [7:0] statusFlags,
   input wire logic retireDevice
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // The flag port trails the readable word by one cycle, so results are checked one edge late.
   sequence s_rd;
      hsel && hready && htrans == ops_pkg::HTRANS_NONSEQ && !hwrite
         && haddr == ops_pkg::STATUS_ADDR;
   endsequence
   sequence s_sec;
      loadStart && loadSelect ##1 loadSecHit ##2 loadDone;
   endsequence
   sequence s_ded;
      loadStart && loadSelect ##2 loadDedHit ##1 loadDone;
   endsequence
   sequence s_start;
      progStart && !loadDone ##1 !statusFlags[4]
         && !(progLowEvt || progHighEvt || progDone || loadDone);
   endsequence
   AST_BUS_OKAY: assert property (hreadyout && hresp == ops_pkg::HRESP_OKAY)
      else $error("bus answer not ready or not okay");
   AST_READ: assert property (s_rd |=> hrdata == {24'h000000, statusFlags})
      else $error("status read data differs from flags");
   AST_FORMAT: assert property (statusFlags[4] ==
      $past((statusFlags[2] | statusFlags[1]) & !statusFlags[0]))
      else $error("format fault flag wrong");
   AST_ATTEMPT: assert property (s_start |=> statusFlags[3:0] == 4'h7)
      else $error("attempt start did not set low bits");
   AST_TRY_CAUSE: assert property ($rose(statusFlags[0]) |->
      $past(progStart, 2) || $past(loadDone, 2))
      else $error("attempt flag rose without cause");
   AST_UV_WITH_OV: assert property ($past(progHighEvt, 2)
      && $fell(statusFlags[1]) |-> !statusFlags[2])
      else $error("overvoltage without undervoltage");
   AST_RETIRE_SET: assert property ($rose(retireDevice) |-> $past(progHighEvt))
      else $error("retire rose without overvoltage");
   AST_RETIRE_HOLD: assert property (retireDevice |=> retireDevice)
      else $error("retire dropped");
   AST_LOAD_CLEAR: assert property (loadStart && loadSelect |=> ##1 statusFlags[7:5] == 3'h0)
      else $error("load start did not clear load flags");
   AST_UNSELECT: assert property (loadStart && !loadSelect |=> ##1 statusFlags[7:5] == 3'h0)
      else $error("unselected load left load flags set");
   AST_SEC: assert property (s_sec |=> ##1 statusFlags[7] && statusFlags[6])
      else $error("repair warning not reported");
   AST_DED: assert property (s_ded |=> ##1 statusFlags[7] && statusFlags[5])
      else $error("load error not reported");
endmodule
bind ops_otp_page2_status ops_otp_page2_status_chk i_ops_otp_page2_status_chk (
   .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .loadStart(loadStart), .loadSelect(loadSelect),
   .loadSecHit(loadSecHit), .loadDedHit(loadDedHit), .loadDone(loadDone),
   .progStart(progStart), .progLowEvt(progLowEvt), .progHighEvt(progHighEvt),
   .progDone(progDone), .statusFlags(statusFlags), .retireDevice(retireDevice)
);

// >>> ops_otp_page2_status_test.sv
// Self-checking testbench for the second-page OTP status block.
`timescale 1ns/1ps
module ops_otp_page2_status_test;
   logic ref_clk, rst, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic loadStart, loadSelect, loadSecHit, loadDedHit, loadDone, progStart, progLowEvt;
   logic progHighEvt, progDone, progPass, progPermit, retireDevice;
   logic [3:0] loadProgImage;
   logic [7:0] statusFlags;
   wire logic hready;
   int n_fail, checks;
   assign hready = hreadyout;

   ops_otp_page2_status i_ops_otp_page2_status (
      .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .loadStart(loadStart), .loadSelect(loadSelect),
      .loadSecHit(loadSecHit), .loadDedHit(loadDedHit), .loadDone(loadDone),
      .loadProgImage(loadProgImage), .progStart(progStart), .progLowEvt(progLowEvt),
      .progHighEvt(progHighEvt), .progDone(progDone), .progPass(progPass),
      .statusFlags(statusFlags), .progPermit(progPermit), .retireDevice(retireDevice),
      .irq(irq)
   );

   always #20 ref_clk = ~ref_clk;

   task automatic final_report();
      $display("Checks %0d, failures %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Values read right after an edge are the ones sampled at that edge.
   task automatic rdy();
      int n;
      n = 0;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            n_fail++;
            $display("Error hready expected 1 seen %b", hreadyout);
            final_report();
         end
         @(posedge ref_clk);
      end
   endtask

   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= ops_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= ops_pkg::HSIZE_WORD;
      rdy();
      htrans <= ops_pkg::HTRANS_IDLE;
      hwdata <= d;
      rdy();
      rd = hrdata;
   endtask

   task automatic st(input logic [7:0] e);
      bus(1'b0, ops_pkg::STATUS_ADDR, 32'h00000000);
      chk("status read", {24'h000000, e}, rd);
      chk("status port", {24'h000000, e}, {24'h000000, statusFlags});
   endtask

   task automatic ld(input logic sel, input logic sec, input logic ded, input logic [3:0] img);
      loadStart <= 1'b1;
      loadSelect <= sel;
      cyc(1);
      loadStart <= 1'b0;
      loadSecHit <= sec;
      cyc(1);
      loadSecHit <= 1'b0;
      loadDedHit <= ded;
      cyc(1);
      loadDedHit <= 1'b0;
      loadDone <= 1'b1;
      loadProgImage <= img;
      cyc(1);
      loadDone <= 1'b0;
      cyc(4);
   endtask

   task automatic pg(input logic lo, input logic hi, input logic pass);
      progStart <= 1'b1;
      cyc(1);
      progStart <= 1'b0;
      progLowEvt <= lo;
      progHighEvt <= hi;
      cyc(1);
      progLowEvt <= 1'b0;
      progHighEvt <= 1'b0;
      progDone <= 1'b1;
      progPass <= pass;
      cyc(1);
      progDone <= 1'b0;
      cyc(4);
   endtask

   task automatic t_reset();
      chk("permit", 32'h00000001, {31'h0, progPermit});
      chk("retire", 32'h00000000, {31'h0, retireDevice});
      chk("irq", 32'h00000000, {31'h0, irq});
      st(8'h00);
      bus(1'b1, ops_pkg::STATUS_ADDR, 32'h000000FF);
      st(8'h00);
      bus(1'b0, ops_pkg::IRQ_MASK_ADDR, 32'h00000000);
      chk("mask reset", 32'h00000000, rd);
      bus(1'b0, 32'h00000100, 32'h00000000);
      chk("unmapped", 32'h00000000, rd);
   endtask

   task automatic t_load();
      ld(1'b1, 1'b1, 1'b1, 4'h0);
      st(8'hE0);
      // A load of another page is no load of page two, so warning and error drop too.
      ld(1'b0, 1'b1, 1'b1, 4'hF);
      st(8'h00);
      ld(1'b1, 1'b0, 1'b0, 4'h6);
      st(8'h96);
      // A start while the format fault stands must leave every flag untouched.
      pg(1'b0, 1'b1, 1'b1);
      st(8'h96);
      chk("permit", 32'h00000000, {31'h0, progPermit});
      chk("retire", 32'h00000000, {31'h0, retireDevice});
      // An image that records the attempt clears the format fault again.
      ld(1'b1, 1'b0, 1'b0, 4'h9);
      st(8'h89);
      chk("permit", 32'h00000001, {31'h0, progPermit});
   endtask

   task automatic t_prog();
      ld(1'b1, 1'b0, 1'b0, 4'h0);
      st(8'h80);
      pg(1'b1, 1'b0, 1'b1);
      st(8'h83);
      pg(1'b0, 1'b0, 1'b1);
      st(8'h8F);
      pg(1'b0, 1'b0, 1'b0);
      st(8'h87);
      pg(1'b0, 1'b1, 1'b1);
      st(8'h81);
      // After this report the bench starts no further attempt.
      chk("retire", 32'h00000001, {31'h0, retireDevice});
   endtask

   task automatic t_irq();
      bus(1'b0, ops_pkg::IRQ_STAT_ADDR, 32'h00000000);
      chk("irq status", 32'h000000FF, rd);
      chk("irq masked", 32'h00000000, {31'h0, irq});
      bus(1'b1, ops_pkg::IRQ_MASK_ADDR, 32'h00000001);
      cyc(2);
      chk("irq unmasked", 32'h00000001, {31'h0, irq});
      bus(1'b1, ops_pkg::IRQ_STAT_ADDR, 32'h000000FF);
      cyc(2);
      chk("irq cleared", 32'h00000000, {31'h0, irq});
      bus(1'b0, ops_pkg::IRQ_STAT_ADDR, 32'h00000000);
      chk("irq status", 32'h00000000, rd);
      bus(1'b0, ops_pkg::IRQ_MASK_ADDR, 32'h00000000);
      chk("mask", 32'h00000001, rd);
   endtask

   initial begin
      ref_clk = 1'b0;
      rst = 1'b1;
      {hsel, hwrite, loadStart, loadSelect, loadSecHit, loadDedHit, loadDone} = 7'h00;
      {progStart, progLowEvt, progHighEvt, progDone, progPass} = 5'h00;
      haddr = 32'h00000000;
      hwdata = 32'h00000000;
      htrans = ops_pkg::HTRANS_IDLE;
      hsize = ops_pkg::HSIZE_WORD;
      loadProgImage = 4'h0;
      n_fail = 0;
      checks = 0;
      cyc(2);
      rst <= 1'b0;
      t_reset();
      t_load();
      t_prog();
      t_irq();
      final_report();
   end
endmodule
